// ### pkg/brg_pkg.sv
package brg_pkg;

    // ------------------------------------------------------------------
    // Register map (byte-wide registers on the plain software port)
    // ------------------------------------------------------------------
    localparam int ADDR_W = 3;
    localparam logic [ADDR_W-1:0] A_TXC = 3'h0;
    localparam logic [ADDR_W-1:0] A_RXC = 3'h1;
    localparam logic [ADDR_W-1:0] A_RCN = 3'h2;
    localparam logic [ADDR_W-1:0] A_DH = 3'h3;
    localparam logic [ADDR_W-1:0] A_DL = 3'h4;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int B_SYNC = 4;
    localparam int B_HSPD = 2;
    localparam int B_TX_EMPTY = 1;
    localparam int B_WIDE = 3;
    localparam int B_IDLE = 6;

    // Reset values and writable-bit masks
    localparam logic [7:0] TXC_RST = 8'h02;
    localparam logic [7:0] RXC_RST = 8'h00;
    localparam logic [7:0] RCN_RST = 8'h40;
    localparam logic [7:0] DIV_RST = 8'h00;
    localparam logic [7:0] TXC_WMASK = 8'hfd;
    localparam logic [7:0] RXC_WMASK = 8'hf9;
    localparam logic [7:0] RCN_WMASK = 8'hbb;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;

    // ------------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------------
    localparam int CW = 23;
    localparam logic [4:0] SH_DIV4 = 5'h2;
    localparam logic [4:0] SH_DIV16 = 5'h4;
    localparam logic [4:0] SH_DIV64 = 5'h6;
    localparam logic [CW-1:0] CNT_ONE = 23'h1;
    localparam logic [CW-1:0] SMP_LEAD = 23'h2;
    localparam int NSMP = 3;

    typedef enum logic [2:0] {
        BRG_DIV4 = 3'b001,
        BRG_DIV16 = 3'b010,
        BRG_DIV64 = 3'b100
    } brg_mode_t;

    // Majority of three samples
    function automatic logic brg_maj(input logic [NSMP-1:0] s);
        brg_maj = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction

endpackage

// ### pkg/brg_vote_if.sv
interface brg_vote_if;
    logic pin;
    logic smp;
    logic done;
    logic level;
    modport ctl (output pin, output smp, output done, input level);
    modport vot (input pin, input smp, input done, output level);
endinterface

// ### rtl/brg_vote.sv
module brg_vote import brg_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    brg_vote_if.vot v
);

    typedef struct packed {
        logic [NSMP-1:0] smp;
        logic level;
    } brg_vote_st_t;

    brg_vote_st_t s_q;
    brg_vote_st_t s_d;

    // Shift in a sample on each strobe, resolve the level at bit end
    always_comb begin
        s_d = s_q;
        if (v.smp) begin
            s_d.smp = {s_q.smp[NSMP-2:0], v.pin};
        end
        if (v.done) begin
            s_d.level = brg_maj(s_d.smp);
        end
    end

    // Idle line is high, so the voter starts high
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '{smp: '1, level: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    assign v.level = s_q.level;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // Judged from the pin history itself, so a broken shift register is caught too
    property p_vote;
        @(posedge clk) disable iff (!rst_n)
        (v.done && v.smp && $past(v.smp) && $past(v.smp, 2))
            |=> v.level == brg_maj({$past(v.pin, 3), $past(v.pin, 2), $past(v.pin)});
    endproperty
    a_vote: assert property (p_vote) else $error("vote level wrong");

endmodule

// ### rtl/brg_top.sv
// Chosen here: the register offsets and the plain strobed port.
module brg_top import brg_pkg::*; (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic RX_PIN,
    output logic RX_LEVEL,
    output logic BIT_TICK,
    output logic SYNC_MODE
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] txc;
        logic [7:0] rxc;
        logic [7:0] rcn;
        logic [7:0] dh;
        logic [7:0] dl;
        logic [CW-1:0] cnt;
        logic tick;
        logic [7:0] rdata;
    } brg_state_t;

    brg_state_t s_q;
    brg_state_t s_d;
    brg_mode_t mode;
    logic [15:0] div_n;
    logic [4:0] shift;
    logic [CW-1:0] lim;
    logic div_wr;
    logic wrap;

    brg_vote_if vif ();

    // ------------------------------------------------------------------
    // Divide mode and terminal count
    // ------------------------------------------------------------------
    // High speed is a don't-care in synchronous mode
    always_comb begin
        if (s_q.txc[B_SYNC]) begin
            mode = BRG_DIV4;
        end else if (s_q.rcn[B_WIDE] & s_q.txc[B_HSPD]) begin
            mode = BRG_DIV4;
        end else if (s_q.rcn[B_WIDE] | s_q.txc[B_HSPD]) begin
            mode = BRG_DIV16;
        end else begin
            mode = BRG_DIV64;
        end
    end

    // Narrow mode drops the high byte entirely
    assign div_n = s_q.rcn[B_WIDE] ? {s_q.dh, s_q.dl} : {8'h00, s_q.dl};

    always_comb begin
        shift = SH_DIV64;
        unique case (mode)
            BRG_DIV4: shift = SH_DIV4;
            BRG_DIV16: shift = SH_DIV16;
            BRG_DIV64: shift = SH_DIV64;
        endcase
    end

    // One counter over the whole bit period avoids a prescaler phase to reset
    assign lim = CW'((CW'(div_n) + CNT_ONE) << shift) - CNT_ONE;
    assign div_wr = WR & ((ADDR == A_DH) | (ADDR == A_DL));
    assign wrap = s_q.cnt >= lim;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        // Free-running counter; a mode change that drops the limit to or below the count wraps at once
        if (div_wr) begin
            s_d.cnt = '0;
        end else if (wrap) begin
            s_d.cnt = '0;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + CNT_ONE;
        end
        // Register writes
        if (WR) begin
            unique case (ADDR)
                A_TXC: s_d.txc = (WDATA & TXC_WMASK) | (s_q.txc & ~TXC_WMASK);
                A_RXC: s_d.rxc = WDATA & RXC_WMASK;
                A_RCN: s_d.rcn = (WDATA & RCN_WMASK) | (s_q.rcn & ~RCN_WMASK);
                A_DH: s_d.dh = WDATA;
                A_DL: s_d.dl = WDATA;
                default: ;
            endcase
        end
        // Read data stands for the cycle after the strobe only
        s_d.rdata = '0;
        if (RD) begin
            unique case (ADDR)
                A_TXC: s_d.rdata = s_q.txc;
                A_RXC: s_d.rdata = s_q.rxc;
                A_RCN: s_d.rdata = s_q.rcn;
                A_DH: s_d.rdata = s_q.dh;
                A_DL: s_d.rdata = s_q.dl;
                default: s_d.rdata = RD_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            s_q <= '{txc: TXC_RST, rxc: RXC_RST, rcn: RCN_RST, dh: DIV_RST, dl: DIV_RST,
                     cnt: '0, tick: 1'b0, rdata: '0};
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Majority sampler: three samples in the last three clocks of a bit
    // ------------------------------------------------------------------
    assign vif.pin = RX_PIN;
    assign vif.smp = !div_wr && (s_q.cnt + SMP_LEAD >= lim);
    assign vif.done = !div_wr && wrap;

    brg_vote u_vote (
        .clk(MCLK),
        .rst_n(RST_N),
        .v(vif.vot)
    );

    assign RDATA = s_q.rdata;
    assign RX_LEVEL = vif.level;
    assign BIT_TICK = s_q.tick;
    assign SYNC_MODE = s_q.txc[B_SYNC];

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [CW-1:0] gap_q;
    logic steady_q;

    // Cycles since the last tick; steady once a full period ran undisturbed
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            gap_q <= '0;
            steady_q <= 1'b0;
        end else begin
            gap_q <= s_q.tick ? CNT_ONE : gap_q + CNT_ONE;
            if (WR) begin
                steady_q <= 1'b0;
            end else if (s_q.tick) begin
                steady_q <= 1'b1;
            end
        end
    end

    property p_period;
        @(posedge MCLK) disable iff (!RST_N)
        (s_q.tick && steady_q && !$past(WR)) |-> gap_q == lim + CNT_ONE;
    endproperty
    a_period: assert property (p_period) else $error("bit period wrong");

    property p_div64;
        @(posedge MCLK) disable iff (!RST_N)
        (!s_q.txc[B_SYNC] && !s_q.rcn[B_WIDE] && !s_q.txc[B_HSPD])
            |-> lim == CW'({s_q.dl, 6'h3f});
    endproperty
    a_div64: assert property (p_div64) else $error("divide by 64 wrong");

    property p_div16;
        @(posedge MCLK) disable iff (!RST_N)
        (!s_q.txc[B_SYNC] && (s_q.rcn[B_WIDE] ^ s_q.txc[B_HSPD]))
            |-> lim == CW'({div_n, 4'hf});
    endproperty
    a_div16: assert property (p_div16) else $error("divide by 16 wrong");

    property p_div4s;
        @(posedge MCLK) disable iff (!RST_N)
        (s_q.txc[B_SYNC] && !s_q.rcn[B_WIDE]) |-> lim == CW'({s_q.dl, 2'h3});
    endproperty
    a_div4s: assert property (p_div4s) else $error("sync divide wrong");

    property p_div4w;
        @(posedge MCLK) disable iff (!RST_N)
        (s_q.rcn[B_WIDE] && (s_q.txc[B_SYNC] || s_q.txc[B_HSPD]))
            |-> lim == CW'({s_q.dh, s_q.dl, 2'h3});
    endproperty
    a_div4w: assert property (p_div4w) else $error("wide divide by 4 wrong");

    property p_narrow;
        @(posedge MCLK) disable iff (!RST_N)
        !s_q.rcn[B_WIDE] |-> div_n[15:8] == 8'h00;
    endproperty
    a_narrow: assert property (p_narrow) else $error("high byte used");

    property p_clear;
        @(posedge MCLK) disable iff (!RST_N)
        div_wr |=> (s_q.cnt == '0) ##1 (s_q.cnt == CNT_ONE || s_q.tick || $past(div_wr));
    endproperty
    a_clear: assert property (p_clear) else $error("counter not cleared");

    sequence s_wr_hi;
        WR && ADDR == A_DH;
    endsequence
    sequence s_rd_hi;
        RD && ADDR == A_DH;
    endsequence
    property p_hi_rw;
        @(posedge MCLK) disable iff (!RST_N)
        s_wr_hi ##1 s_rd_hi |=> RDATA == $past(WDATA, 2);
    endproperty
    a_hi_rw: assert property (p_hi_rw) else $error("high byte readback wrong");

endmodule

// ### dv/brg_line_model.sv
// Remote transmitter on the receive line: holds one level per bit, idles high
module brg_line_model (
    input wire logic clk,
    input wire logic tick,
    input wire logic level,
    input wire logic glitch,
    input wire logic [31:0] lim,
    output logic pin = 1'b1
);
    timeunit 1ns;
    timeprecision 100ps;
    int c = 0;

    // ----------------------------------------
    // Bit timing follows the device tick
    // ----------------------------------------
    // A glitch lands on the last sampled cycle, where a single-sample reader would fail
    always @(posedge clk) begin
        c <= tick ? 1 : c + 1;
        pin <= (glitch && !tick && c + 1 == lim) ? ~level : level;
    end
endmodule

// ### dv/testbench.sv
module testbench import brg_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic rx_pin, rx_level, bit_tick, sync_mode;
    logic lvl = 1'b1;
    logic glt = 1'b0;
    int mismatches = 0;
    int tests_run = 0;
    // Columns: sync, high speed, wide, high byte, low byte, prescale
    int cfg [7][6] = '{'{0, 0, 0, 1, 2, 64}, '{0, 1, 0, 1, 2, 16}, '{0, 0, 1, 1, 2, 16},
        '{0, 1, 1, 1, 2, 4}, '{1, 1, 0, 1, 2, 4}, '{1, 0, 1, 1, 2, 4}, '{1, 0, 0, 0, 255, 4}};

    brg_top DUT (.MCLK(mclk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .RX_PIN(rx_pin), .RX_LEVEL(rx_level), .BIT_TICK(bit_tick),
        .SYNC_MODE(sync_mode));
    brg_line_model line (.clk(mclk), .tick(bit_tick), .level(lvl), .glitch(glt), .lim(3),
        .pin(rx_pin));

    // 125 MHz system clock
    always #4 mclk = ~mclk;

    // ----------------------------------------
    // Access tasks and comparison
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    // Data stand only in the cycle after the strobe, then fall back to zero
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1 chk("read data", rdata, exp);
        @(posedge mclk);
        #1 chk("read data after", rdata, 8'h00);
    endtask

    // Write then read back with no gap between the two strobes
    task automatic wr_rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 chk("read back", rdata, d);
    endtask

    // Bounded wait; returns the number of edges until the tick shows
    task automatic wait_tick(output int k);
        k = 0;
        do begin
            @(posedge mclk);
            #1 k++;
        end while (bit_tick !== 1'b1 && k < 9000);
    endtask

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Whole run is about fifteen thousand cycles
    initial begin
        repeat (60000) @(posedge mclk);
        mismatches++;
        finish_test;
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        int k, n, per;
        repeat (10) @(posedge mclk);
        chk("level in reset", rx_level, 1'b1);
        chk("tick in reset", bit_tick, 1'b0);
        rst_n <= 1'b1;
        // Reset values, unmapped places and read-only bits
        rd_chk(A_TXC, 8'h02);
        rd_chk(A_RXC, 8'h00);
        rd_chk(A_RCN, 8'h40);
        rd_chk(A_DH, 8'h00);
        rd_chk(A_DL, 8'h00);
        rd_chk(3'h5, 8'h00);
        wr_reg(3'h7, 8'hff);
        rd_chk(3'h7, 8'h00);
        wr_reg(A_TXC, 8'h00);
        rd_chk(A_TXC, 8'h02);
        wr_reg(A_RXC, 8'hff);
        rd_chk(A_RXC, 8'hf9);
        wr_reg(A_RCN, 8'hff);
        rd_chk(A_RCN, 8'hfb);
        wr_rd_chk(A_DH, 8'h3c);
        wr_reg(A_DH, 8'ha5);
        wr_reg(A_DL, 8'h5a);
        rd_chk(A_DH, 8'ha5);
        rd_chk(A_DL, 8'h5a);
        $display("test registers done");
        // Every mode: first tick after a divisor write, then the steady period
        for (int i = 0; i < 7; i++) begin
            wr_reg(A_TXC, 8'(cfg[i][0] * 16 + cfg[i][1] * 4));
            #1 chk("sync mode", sync_mode, cfg[i][0]);
            wr_reg(A_RCN, 8'(cfg[i][2] * 8));
            wr_reg(A_DH, 8'(cfg[i][3]));
            wr_reg(A_DL, 8'(cfg[i][4]));
            n = cfg[i][2] ? cfg[i][3] * 256 + cfg[i][4] : cfg[i][4];
            per = cfg[i][5] * (n + 1);
            wait_tick(k);
            chk("first tick", k, per);
            wait_tick(k);
            chk("period", k, per);
        end
        $display("test rates done");
        // Asynchronous, wide and high speed with divisor zero: four cycles a bit
        wr_reg(A_TXC, 8'h04);
        wr_reg(A_RCN, 8'h08);
        wr_reg(A_DH, 8'h00);
        wr_reg(A_DL, 8'h00);
        wait_tick(k);
        for (int b = 0; b < 4; b++) begin
            lvl <= b[0];
            glt <= 1'b1;
            wait_tick(k);
            chk("voted level", rx_level, b[0]);
        end
        $display("test vote done");
        finish_test;
    end
endmodule
